/* File: rtl/irc_pkg.sv */
package irc_pkg;

  // register byte addresses within the system control space window
  localparam logic [19:0] IRC_OFFSET = 20'h0ed0c;
  localparam logic [19:0] IRC_ALIAS_OFFSET = 20'h2ed0c;

  // key values
  localparam logic [15:0] IRC_WRITE_KEY = 16'h05fa;
  localparam logic [15:0] IRC_KEY_STATUS = 16'hfa05;

  // field positions
  localparam int IRC_KEY_LSB = 16;
  localparam int IRC_ENDIAN_BIT = 15;
  localparam int IRC_BOOST_BIT = 14;
  localparam int IRC_ROUTE_BIT = 13;
  localparam int IRC_SPLIT_LSB = 8;
  localparam int IRC_SPLIT_W = 3;
  localparam int IRC_RSO_BIT = 3;
  localparam int IRC_REQ_BIT = 2;
  localparam int IRC_CLR_BIT = 1;

  // values after warm reset
  localparam logic IRC_BOOST_RST = 1'b0;
  localparam logic IRC_ROUTE_RST = 1'b0;
  localparam logic IRC_ROUTE_NOSEC = 1'b1;
  localparam logic [2:0] IRC_SPLIT_RST = 3'h0;
  localparam logic IRC_RSO_RST = 1'b0;
  localparam logic IRC_REQ_RST = 1'b0;
  localparam logic [31:0] IRC_RDATA_RST = 32'h00000000;

  // full word strobe
  localparam logic [3:0] IRC_STRB_WORD = 4'hf;

endpackage : irc_pkg

/* File: rtl/irc_field.sv */
`timescale 1ns/10ps
module irc_field
  import irc_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0,
  parameter bit WRITABLE = 1'b1
) (
  input wire logic clock_i, // core clock
  input wire logic reset_i, // warm reset, async high
  input wire logic we_i, // accepted write to this field
  input wire logic [W-1:0] d_i, // new value
  output logic [W-1:0] q_o // stored value
);

  typedef struct packed {
    logic [W-1:0] val;
  } irc_field_s;

  irc_field_s st;
  irc_field_s next_st;

  // refuse a field with no bits
  if (W < 1) begin : g_bad_width
    $error("irc_field width must be at least one");
  end

  // a locked field keeps its reset value
  always_comb begin
    next_st = st;
    if (WRITABLE && we_i) begin
      next_st.val = d_i;
    end
  end

  // state register
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '{val: RST};
    end else begin
      st <= next_st;
    end
  end

  assign q_o = st.val;

endmodule : irc_field

/* File: rtl/irc_clract.sv */
`timescale 1ns/10ps
module irc_clract
  import irc_pkg::*;
(
  input wire logic clock_i, // core clock
  input wire logic reset_i, // warm reset, async high
  input wire logic go_i, // keyed debugger write of one to the clear bit
  input wire logic halted_i, // core halted in debug state
  input wire logic sde_i, // secure debug enabled
  output logic clear_ns_o, // pulse: clear non-secure active states
  output logic clear_s_o, // pulse: clear secure active states
  output logic clear_exception_number_field_o // pulse: zero the exception number field
);

  typedef struct packed {
    logic ns;
    logic s;
    logic exception_number_field;
  } irc_clract_s;

  irc_clract_s st;
  irc_clract_s next_st;

  // one-cycle clear pulses, only while halted
  always_comb begin
    next_st.ns = go_i & halted_i;
    next_st.exception_number_field = go_i & halted_i;
    next_st.s = go_i & halted_i & sde_i;
  end

  // state register
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign clear_ns_o = st.ns;
  assign clear_s_o = st.s;
  assign clear_exception_number_field_o = st.exception_number_field;

endmodule : irc_clract

/* File: rtl/irc_top.sv */
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module irc_top
  import irc_pkg::*;
#(
  parameter bit HAS_SECURITY = 1'b1,
  parameter bit HAS_MAIN_EXT = 1'b1,
  parameter bit BIG_ENDIAN = 1'b0,
  parameter bit BOOST_WRITABLE = 1'b1,
  parameter bit ROUTE_WRITABLE = 1'b1
) (
  input wire logic CLOCK_I, // core clock, 10 MHz
  input wire logic RESET_I, // warm reset, async high
  input wire logic PSEL_I, // apb select
  input wire logic PENABLE_I, // apb access phase
  input wire logic PWRITE_I, // apb write
  input wire logic [19:0] PADDR_I, // apb byte address
  input wire logic [31:0] PWDATA_I, // apb write data
  input wire logic [3:0] PSTRB_I, // apb byte strobes
  input wire logic [2:0] PPROT_I, // [0] privileged, [1] non-secure
  input wire logic DEBUG_I, // access comes from the debugger
  input wire logic HALTED_I, // core halted in debug state
  input wire logic SECURE_DEBUG_EN_I, // secure debug enabled
  output logic [31:0] PRDATA_O, // apb read data
  output logic PREADY_O, // apb ready
  output logic PSLVERR_O, // apb error
  output logic SECURE_BOOST_O, // non-secure exceptions lowered
  output logic FAULT_NS_O, // faults and nmi routed non-secure
  output logic [2:0] SPLIT_S_O, // secure priority split point
  output logic [2:0] SPLIT_NS_O, // non-secure priority split point
  output logic RESET_SECURE_ONLY_O, // reset request secure only
  output logic SYS_RESET_REQ_O, // held system reset request
  output logic CLEAR_ACTIVE_NS_O, // pulse: clear non-secure actives
  output logic CLEAR_ACTIVE_S_O, // pulse: clear secure actives
  output logic CLEAR_EXCEPTION_NUMBER_FIELD_O // pulse: zero exception number field
);

  typedef struct packed {
    logic ready;
    logic slverr;
    logic [31:0] rdata;
    logic req;
  } irc_top_s;

  irc_top_s st;
  irc_top_s next_st;

  // refuse package layouts that the address decode, key check and read word assembly cannot serve
  if (IRC_SPLIT_W != 3) begin : g_bad_split_width
    $error("irc_top needs a three-bit split point field");
  end
  if (IRC_KEY_LSB != 16) begin : g_bad_key_position
    $error("irc_top needs the key in the upper half-word");
  end
  if (IRC_KEY_STATUS != ~IRC_WRITE_KEY) begin : g_bad_key_status
    $error("irc_top key status must be the inverse of the write key");
  end
  if (IRC_ENDIAN_BIT >= IRC_KEY_LSB) begin : g_bad_endian_position
    $error("irc_top endianness bit overlaps the key");
  end
  if (IRC_ROUTE_BIT >= IRC_BOOST_BIT || IRC_BOOST_BIT >= IRC_ENDIAN_BIT) begin : g_bad_sec_bits
    $error("irc_top security control bits out of order");
  end
  if (IRC_SPLIT_LSB + IRC_SPLIT_W > IRC_ROUTE_BIT) begin : g_bad_split_position
    $error("irc_top split point overlaps the routing bit");
  end
  if (IRC_RSO_BIT >= IRC_SPLIT_LSB) begin : g_bad_rso_position
    $error("irc_top restriction bit overlaps the split point");
  end
  if (IRC_CLR_BIT >= IRC_REQ_BIT || IRC_REQ_BIT >= IRC_RSO_BIT) begin : g_bad_low_bits
    $error("irc_top low control bits out of order");
  end
  if (IRC_OFFSET == IRC_ALIAS_OFFSET) begin : g_bad_alias
    $error("irc_top alias must differ from the main offset");
  end
  if (IRC_STRB_WORD != 4'hf) begin : g_bad_strobe
    $error("irc_top honours full word writes only");
  end
  if (IRC_RDATA_RST != 32'h00000000) begin : g_bad_rdata_rst
    $error("irc_top read bus must rest at zero after reset");
  end
  if (IRC_ROUTE_NOSEC != 1'b1) begin : g_bad_route_nosec
    $error("irc_top routing bit must read one without a secure state");
  end

  // field values held in the field modules
  logic boost;
  logic route;
  logic [2:0] split_s;
  logic [2:0] split_ns;
  logic rso;

  // address decode and security view
  logic hit_main;
  logic hit_alias;
  logic ns_req;
  logic alias_raz;
  logic ns_view;
  logic bad_access;
  logic setup;
  logic commit;
  logic key_ok;
  logic we;
  logic [2:0] split_view;
  logic [31:0] rd_word;

  // decode of the current request
  assign hit_main = (PADDR_I == IRC_OFFSET);
  // the alias only exists where a secure state does
  assign hit_alias = HAS_SECURITY && (PADDR_I == IRC_ALIAS_OFFSET);
  // without a secure state every access is treated as secure
  assign ns_req = HAS_SECURITY && PPROT_I[1];
  // the alias is zero to non-secure software and to the debugger
  assign alias_raz = hit_alias & (ns_req | DEBUG_I);
  // secure software in the alias sees the non-secure view
  assign ns_view = ns_req | hit_alias;
  // unmapped or unprivileged accesses end in an error
  logic mapped;
  logic priv_ok;
  assign mapped = hit_main | hit_alias;
  assign priv_ok = PPROT_I[0];
  assign bad_access = ~mapped | ~priv_ok;

  // phase decode: the access phase is the cycle in which ready stands
  logic access;
  assign setup = PSEL_I & ~PENABLE_I;
  assign access = PSEL_I & PENABLE_I & st.ready;
  assign commit = access & PWRITE_I & ~st.slverr;

  // key check: wrong key or partial word changes nothing
  assign key_ok = (PWDATA_I[31:IRC_KEY_LSB] == IRC_WRITE_KEY)
    & (PSTRB_I == IRC_STRB_WORD) & ~alias_raz;
  assign we = commit & key_ok;

  // write enables of the single fields, all behind the key check
  logic we_secure;
  logic we_nonsec;
  logic we_req;
  logic go_clear;
  assign we_secure = we & ~ns_view;
  assign we_nonsec = we & ns_view;
  // a non-secure request is dropped while the restriction bit is set
  assign we_req = we & PWDATA_I[IRC_REQ_BIT] & ~(ns_view & rso);
  // only a debugger write may start the clear of the active states
  assign go_clear = we & PWDATA_I[IRC_CLR_BIT] & DEBUG_I;

  // banked split point of the selected view
  assign split_view = ns_view ? split_ns : split_s;

  // bits hidden from the non-secure view read zero
  logic boost_view;
  logic rso_view;
  logic req_view;
  assign boost_view = ns_view ? 1'b0 : boost;
  assign rso_view = ns_view ? 1'b0 : rso;
  assign req_view = (ns_view & rso) ? 1'b0 : st.req;

  // read word assembly
  always_comb begin
    rd_word = '0;
    // key status and fixed endianness, shared by both views
    rd_word[31:IRC_KEY_LSB] = IRC_KEY_STATUS;
    rd_word[IRC_ENDIAN_BIT] = BIG_ENDIAN;
    // security controls as the selected view may see them
    rd_word[IRC_BOOST_BIT] = boost_view;
    rd_word[IRC_ROUTE_BIT] = route;
    // split point of the view, reserved without the main extension
    if (HAS_MAIN_EXT) begin
      rd_word[IRC_SPLIT_LSB +: IRC_SPLIT_W] = split_view;
    end else begin
      rd_word[IRC_SPLIT_LSB +: IRC_SPLIT_W] = 3'h0;
    end
    // reset controls; the clear bit and the reserved bits read zero
    rd_word[IRC_RSO_BIT] = rso_view;
    rd_word[IRC_REQ_BIT] = req_view;
    rd_word[IRC_CLR_BIT] = 1'b0;
    // the alias seen from outside and refused accesses return zero
    if (alias_raz | bad_access) begin
      rd_word = '0;
    end
  end

  // bus answer and reset request
  always_comb begin
    next_st = st;
    // ready is raised for exactly the access phase after a setup
    next_st.ready = setup;
    // error and read word are decided from the setup cycle
    if (setup) begin
      next_st.slverr = bad_access;
      if (PWRITE_I) begin
        // a write leaves no stale word on the read bus
        next_st.rdata = '0;
      end else begin
        next_st.rdata = rd_word;
      end
    end else begin
      next_st.slverr = 1'b0;
    end
    // request stays until warm reset removes it; writing zero never clears it
    if (we_req) begin
      next_st.req = 1'b1;
    end
  end

  // state register, cleared by warm reset
  always_ff @(posedge CLOCK_I or posedge RESET_I) begin
    if (RESET_I) begin
      st <= '{ready: 1'b0, slverr: 1'b0, rdata: IRC_RDATA_RST, req: IRC_REQ_RST};
    end else begin
      st <= next_st;
    end
  end

  // secure priority boost, secure writes only
  irc_field #(
    .W(1),
    .RST(IRC_BOOST_RST),
    .WRITABLE(HAS_SECURITY && BOOST_WRITABLE)
  ) u_boost (
    .clock_i(CLOCK_I),
    .reset_i(RESET_I),
    .we_i(we_secure),
    .d_i(PWDATA_I[IRC_BOOST_BIT]),
    .q_o(boost)
  );

  // fault routing, reads one and locked without a secure state
  irc_field #(
    .W(1),
    .RST(HAS_SECURITY ? IRC_ROUTE_RST : IRC_ROUTE_NOSEC),
    .WRITABLE(HAS_SECURITY && ROUTE_WRITABLE)
  ) u_route (
    .clock_i(CLOCK_I),
    .reset_i(RESET_I),
    .we_i(we_secure),
    .d_i(PWDATA_I[IRC_ROUTE_BIT]),
    .q_o(route)
  );

  // secure bank of the split point
  irc_field #(
    .W(IRC_SPLIT_W),
    .RST(IRC_SPLIT_RST),
    .WRITABLE(HAS_MAIN_EXT)
  ) u_split_s (
    .clock_i(CLOCK_I),
    .reset_i(RESET_I),
    .we_i(we_secure),
    .d_i(PWDATA_I[IRC_SPLIT_LSB +: IRC_SPLIT_W]),
    .q_o(split_s)
  );

  // non-secure bank of the split point
  irc_field #(
    .W(IRC_SPLIT_W),
    .RST(IRC_SPLIT_RST),
    .WRITABLE(HAS_MAIN_EXT)
  ) u_split_ns (
    .clock_i(CLOCK_I),
    .reset_i(RESET_I),
    .we_i(we_nonsec),
    .d_i(PWDATA_I[IRC_SPLIT_LSB +: IRC_SPLIT_W]),
    .q_o(split_ns)
  );

  // reset request restriction, secure writes only
  irc_field #(
    .W(1),
    .RST(IRC_RSO_RST),
    .WRITABLE(HAS_SECURITY)
  ) u_rso (
    .clock_i(CLOCK_I),
    .reset_i(RESET_I),
    .we_i(we_secure),
    .d_i(PWDATA_I[IRC_RSO_BIT]),
    .q_o(rso)
  );

  // debugger clear of the active states, the secure ones only while secure debug is enabled
  irc_clract u_clract (
    .clock_i(CLOCK_I),
    .reset_i(RESET_I),
    .go_i(go_clear),
    .halted_i(HALTED_I),
    .sde_i(SECURE_DEBUG_EN_I),
    .clear_ns_o(CLEAR_ACTIVE_NS_O),
    .clear_s_o(CLEAR_ACTIVE_S_O),
    .clear_exception_number_field_o(CLEAR_EXCEPTION_NUMBER_FIELD_O)
  );

  // bus answer straight from the state register
  assign PRDATA_O = st.rdata;
  assign PREADY_O = st.ready;
  assign PSLVERR_O = st.slverr;

  // reset request held to the reset controller
  assign SYS_RESET_REQ_O = st.req;

  // field values to the prioritisation logic, straight from flip-flops
  assign SECURE_BOOST_O = boost;
  assign FAULT_NS_O = route;
  assign SPLIT_S_O = split_s;
  assign SPLIT_NS_O = split_ns;
  assign RESET_SECURE_ONLY_O = rso;

endmodule : irc_top

/* File: tb/irc_top_monitor.sv */
`timescale 1ns/10ps
module irc_top_monitor
  import irc_pkg::*;
(
  input wire logic CLOCK_I, // clock
  input wire logic RESET_I, // reset
  input wire logic PWRITE_I, // write
  input wire logic [31:0] PWDATA_I, // wdata
  input wire logic [2:0] PPROT_I, // prot
  input wire logic DEBUG_I, // debugger
  input wire logic HALTED_I, // halted
  input wire logic SECURE_DEBUG_EN_I, // sde
  input wire logic [31:0] PRDATA_O, // rdata
  input wire logic PREADY_O, // ready
  input wire logic PSLVERR_O, // error
  input wire logic SECURE_BOOST_O, // boost
  input wire logic [2:0] SPLIT_S_O, // split
  input wire logic SYS_RESET_REQ_O, // request
  input wire logic CLEAR_ACTIVE_NS_O, // ns clear
  input wire logic CLEAR_ACTIVE_S_O, // s clear
  input wire logic CLEAR_EXCEPTION_NUMBER_FIELD_O // exception_number_field clear
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);
  // read word, write key and side effects
  a_key_status: assert property (PREADY_O && !PWRITE_I && !PSLVERR_O && PPROT_I == 3'h1
    && !DEBUG_I |-> PRDATA_O[31:16] == IRC_KEY_STATUS) else $error("key status wrong");
  a_reserved_zero: assert property (PREADY_O && !PWRITE_I |->
    (PRDATA_O & 32'h000018f3) == 32'h0) else $error("reserved bits set");
  a_ns_view: assert property (PREADY_O && !PWRITE_I && PPROT_I[1] |->
    !PRDATA_O[14] && !PRDATA_O[3]) else $error("ns view leaks");
  a_no_key: assert property (PREADY_O && PWRITE_I && PWDATA_I[31:16] != IRC_WRITE_KEY
    |=> $stable(SECURE_BOOST_O) && $stable(SPLIT_S_O) && !CLEAR_EXCEPTION_NUMBER_FIELD_O && !$rose(SYS_RESET_REQ_O))
    else $error("unkeyed write acted");
  a_req_held: assert property (SYS_RESET_REQ_O |=> SYS_RESET_REQ_O)
    else $error("request dropped");
  a_req_cause: assert property ($rose(SYS_RESET_REQ_O) |->
    $past(PREADY_O && PWRITE_I && PWDATA_I[2])) else $error("request without write");
  a_clear_cause: assert property (CLEAR_EXCEPTION_NUMBER_FIELD_O |-> $past(PREADY_O && PWRITE_I && DEBUG_I
    && HALTED_I && PWDATA_I[1])) else $error("clear without halted debugger");
  a_clear_pulse: assert property (CLEAR_EXCEPTION_NUMBER_FIELD_O |-> CLEAR_ACTIVE_NS_O ##1 !CLEAR_EXCEPTION_NUMBER_FIELD_O)
    else $error("clear pulse wrong");
  a_clear_secure: assert property (CLEAR_ACTIVE_S_O |-> CLEAR_ACTIVE_NS_O
    && $past(SECURE_DEBUG_EN_I)) else $error("secure clear wrong");
endmodule : irc_top_monitor
bind irc_top irc_top_monitor i_irc_top_monitor (.CLOCK_I, .RESET_I, .PWRITE_I, .PWDATA_I,
  .PPROT_I, .DEBUG_I, .HALTED_I, .SECURE_DEBUG_EN_I, .PRDATA_O, .PREADY_O, .PSLVERR_O,
  .SECURE_BOOST_O, .SPLIT_S_O, .SYS_RESET_REQ_O, .CLEAR_ACTIVE_NS_O, .CLEAR_ACTIVE_S_O,
  .CLEAR_EXCEPTION_NUMBER_FIELD_O);

/* File: tb/irc_far_model.sv */
`timescale 1ns/10ps
module irc_far_model (
  input wire logic clock_i, // core clock
  input wire logic req_i, // held reset request
  input wire logic clr_ns_i, // clear non-secure actives
  input wire logic clr_s_i, // clear secure actives
  output logic rst_o = 1'b0, // warm reset back to the block
  output logic [7:0] n_ns_o = 8'h0, // non-secure clears seen
  output logic [7:0] n_s_o = 8'h0 // secure clears seen
);
  logic [1:0] wait_q = 2'h0;
  // reset controller answers a held request after four cycles
  always @(posedge clock_i) begin
    rst_o <= 1'b0;
    if (req_i && !rst_o) begin
      wait_q <= wait_q + 2'h1;
      if (wait_q == 2'h3) rst_o <= 1'b1;
    end
  end
  // prioritisation logic tallies active-state clears
  always @(posedge clock_i) begin
    if (clr_ns_i) n_ns_o <= n_ns_o + 8'h1;
    if (clr_s_i) n_s_o <= n_s_o + 8'h1;
  end
endmodule : irc_far_model

/* File: tb/testbench.sv */
`timescale 1ns/10ps
module testbench
  import irc_pkg::*;
;
  logic clk = 1'b0, por = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic dbg = 1'b0, hlt = 1'b0, sde = 1'b0, rerr, pready, pslverr, far_rst, clr_ns, clr_s;
  logic [19:0] padr = 20'h0;
  logic [31:0] pwd = 32'h0, rdat, prdata;
  logic [2:0] prot = 3'h1;
  logic [3:0] strb = 4'hf;
  logic [9:0] outs;
  logic [7:0] n_ns, n_s;
  int mismatches = 0, n_tests = 0;
  // clock
  initial begin
    forever #50 clk = ~clk;
  end
  irc_top i_irc_top (.CLOCK_I(clk), .RESET_I(por | far_rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PSTRB_I(strb), .PPROT_I(prot),
    .DEBUG_I(dbg), .HALTED_I(hlt), .SECURE_DEBUG_EN_I(sde), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .SECURE_BOOST_O(outs[9]), .FAULT_NS_O(outs[8]),
    .SPLIT_S_O(outs[7:5]), .SPLIT_NS_O(outs[4:2]), .RESET_SECURE_ONLY_O(outs[1]),
    .SYS_RESET_REQ_O(outs[0]), .CLEAR_ACTIVE_NS_O(clr_ns), .CLEAR_ACTIVE_S_O(clr_s),
    .CLEAR_EXCEPTION_NUMBER_FIELD_O());
  irc_far_model i_irc_far_model (.clock_i(clk), .req_i(outs[0]), .clr_ns_i(clr_ns),
    .clr_s_i(clr_s), .rst_o(far_rst), .n_ns_o(n_ns), .n_s_o(n_s));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d,
    input logic [2:0] p);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    prot <= p;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic rd(input logic [19:0] a, input logic [2:0] p, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, p);
    chk(rdat, exp);
    chk({31'h0, rerr}, 32'h0);
  endtask : rd
  task automatic t_fields;
    rd(IRC_OFFSET, 3'h1, 32'hfa050000);
    chk({22'h0, outs}, 32'h0);
    apb(1'b1, IRC_OFFSET, 32'h0000c508, 3'h1);
    rd(IRC_OFFSET, 3'h1, 32'hfa050000);
    strb <= 4'h3;
    apb(1'b1, IRC_OFFSET, 32'h05fac508, 3'h1);
    strb <= 4'hf;
    rd(IRC_OFFSET, 3'h1, 32'hfa050000);
    apb(1'b0, IRC_OFFSET, 32'h0, 3'h0);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b1, IRC_OFFSET, 32'h05fac508, 3'h1);
    rd(IRC_OFFSET, 3'h1, 32'hfa054508);
    chk({22'h0, outs}, 32'h2a2);
  endtask : t_fields
  task automatic t_nonsecure;
    apb(1'b1, IRC_OFFSET, 32'h05fa6704, 3'h3);
    rd(IRC_OFFSET, 3'h3, 32'hfa050700);
    chk({22'h0, outs}, 32'h2be);
    rd(IRC_ALIAS_OFFSET, 3'h1, 32'hfa050700);
    apb(1'b0, 20'h0ed10, 32'h0, 3'h1);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b1, IRC_OFFSET, 32'h05fa2000, 3'h1);
    rd(IRC_OFFSET, 3'h3, 32'hfa052700);
    chk({22'h0, outs}, 32'h11c);
  endtask : t_nonsecure
  task automatic t_clear;
    for (int i = 0; i < 4; i++) begin
      dbg <= (i != 0);
      hlt <= (i != 1);
      sde <= (i != 3);
      apb(1'b1, IRC_OFFSET, 32'h05fa0002, 3'h1);
      repeat (2) @(posedge clk);
      chk({16'h0, n_ns, n_s}, {16'h0, 8'(i < 2 ? 0 : i - 1), 8'(i > 1)});
    end
    dbg <= 1'b0;
  endtask : t_clear
  task automatic t_sysreset;
    apb(1'b1, IRC_OFFSET, 32'h05fa0004, 3'h1);
    @(posedge clk);
    chk({22'h0, outs}, 32'h01d);
    repeat (8) @(posedge clk);
    chk({22'h0, outs}, 32'h0);
    rd(IRC_OFFSET, 3'h3, 32'hfa050000);
  endtask : t_sysreset
  task automatic tally_and_finish;
    if (mismatches == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    por <= 1'b0;
    t_fields();
    t_nonsecure();
    t_clear();
    t_sysreset();
    tally_and_finish();
  end
  // watchdog
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
endmodule : testbench
